// ### include/tmr_pkg.sv
// Purpose: Shared constants and types of the 16-bit timer with capture/compare
// Assumes: APB byte address = register index * 4; data in bits 7:0
// Notes: Mode sets are bit masks indexed by the 4-bit waveform mode
package tmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address is index * 4)
  localparam logic [7:0] IDX_CTRL_A = 8'h80;
  localparam logic [7:0] IDX_CTRL_B = 8'h81;
  localparam logic [7:0] IDX_CTRL_C = 8'h82;
  localparam logic [7:0] IDX_AUX = 8'h83;
  localparam logic [7:0] IDX_CNT_L = 8'h84;
  localparam logic [7:0] IDX_CNT_H = 8'h85;
  localparam logic [7:0] IDX_CMPA_L = 8'h86;
  localparam logic [7:0] IDX_CMPA_H = 8'h87;
  localparam logic [7:0] IDX_CAP_L = 8'h88;
  localparam logic [7:0] IDX_CAP_H = 8'h89;
  localparam logic [7:0] IDX_CMPB_L = 8'h8a;
  localparam logic [7:0] IDX_CMPB_H = 8'h8b;
  localparam logic [7:0] IDX_MASK = 8'h8d;
  localparam logic [7:0] IDX_FLAGS = 8'h8e;

  // Reset values and writable-bit masks
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] CTLA_WMASK = 8'hf3;
  localparam logic [7:0] CTLB_WMASK = 8'hdf;
  localparam logic [7:0] MASK_WMASK = 8'h27;

  // Field positions
  localparam int CTLB_FILT_BIT = 7;
  localparam int CTLB_EDGE_BIT = 6;
  localparam int CTLC_FORCE_A_BIT = 7;
  localparam int CTLC_FORCE_B_BIT = 6;
  localparam int CTLA_COM_A_LSB = 6;
  localparam int CTLA_COM_B_LSB = 4;
  localparam int AUX_ACOMP_BIT = 0;
  localparam int FL_CAP_BIT = 5;
  localparam int FL_MB_BIT = 2;
  localparam int FL_MA_BIT = 1;
  localparam int FL_OV_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Counter tops and waveform mode sets
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [15:0] SET_DUAL = 16'h0f0e;
  localparam logic [15:0] SET_NONPWM = 16'h1011;
  localparam logic [15:0] SET_ICR_TOP = 16'h5500;
  localparam logic [15:0] SET_TOGGLE_A = 16'hcf00;

  // Prescaler taps as all-ones masks of a free 10-bit counter
  localparam int PS_W = 10;
  localparam logic [9:0] PS_MASK_8 = 10'h007;
  localparam logic [9:0] PS_MASK_64 = 10'h03f;
  localparam logic [9:0] PS_MASK_256 = 10'h0ff;
  localparam logic [9:0] PS_MASK_1024 = 10'h3ff;
  localparam int FILT_SAMPLES = 4;

  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIV1 = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } tmr_clk_sel_t;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } tmr_dir_t;

endpackage

// ### src/tmr_capture_filter.sv
// Purpose: Capture source select, pin synchronisers and noise filter
// Assumes: Both sources are asynchronous to ref_clk_i
// Notes: Filter output holds until a full window of equal samples
module tmr_capture_filter import tmr_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic capture_pin_i,
  input wire logic acomp_i,
  input wire logic src_acomp_i,
  input wire logic filter_en_i,
  output logic filt_o
);

  logic [1:0] raw;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [FILT_SAMPLES-2:0] hist;
  logic src;
  logic [FILT_SAMPLES-1:0] win;

  assign raw = {acomp_i, capture_pin_i};

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, one per source
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
      end else begin
        sync1[i] <= raw[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  // Comparator output as alternative capture source
  assign src = src_acomp_i ? sync2[1] : sync2[0];
  assign win = {hist, src};

  // Sample history; the current sample completes the window
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hist <= '0;
    end else begin
      hist <= win[FILT_SAMPLES-2:0];
    end
  end

  // Change only on a full window of equal samples; with the filter off, follow directly
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      filt_o <= 1'b0;
    end else if (!filter_en_i) begin
      filt_o <= src;
    end else if (&win) begin
      filt_o <= 1'b1;
    end else if (~|win) begin
      filt_o <= 1'b0;
    end
  end

  a_filter_rise_four: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(filt_o) && $past(filter_en_i) |-> $past(win) == 4'hf)
    else $error("filtered capture rose without four high samples");

endmodule

// ### src/tmr_tick_gen.sv
// Purpose: Timer tick from prescaler taps or the external count pin
// Assumes: External pin slower than half of ref_clk_i
// Notes: Prescaler runs free, so the first prescaled tick may come early
module tmr_tick_gen import tmr_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input tmr_clk_sel_t clock_select_i,
  input wire logic ext_count_pin_i,
  output logic tick_o
);

  logic [PS_W-1:0] presc;
  logic ext_s1;
  logic ext_s2;
  logic ext_prev;
  logic next_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running prescaler, shared taps
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      presc <= '0;
    end else begin
      presc <= presc + 10'h001;
    end
  end

  // Pin level taken whatever its port direction, so software may count
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_s1 <= ext_count_pin_i;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  // Tick selection
  always_comb begin
    unique case (clock_select_i)
      CS_STOP: next_tick = 1'b0;
      CS_DIV1: next_tick = 1'b1;
      CS_DIV8: next_tick = (presc & PS_MASK_8) == PS_MASK_8;
      CS_DIV64: next_tick = (presc & PS_MASK_64) == PS_MASK_64;
      CS_DIV256: next_tick = (presc & PS_MASK_256) == PS_MASK_256;
      CS_DIV1024: next_tick = (presc & PS_MASK_1024) == PS_MASK_1024;
      CS_EXT_FALL: next_tick = ext_prev & ~ext_s2;
      CS_EXT_RISE: next_tick = ext_s2 & ~ext_prev;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= next_tick;
    end
  end

  a_stop_no_tick: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clock_select_i == CS_STOP |=> !tick_o)
    else $error("tick while clock stopped");
  a_div8_tick: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clock_select_i == CS_DIV8 && presc[2:0] != 3'h7 |=> !tick_o)
    else $error("divide-by-8 tick off its tap");
  a_ext_rise: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clock_select_i == CS_EXT_RISE && ext_s1 && !ext_s2 ##1 clock_select_i == CS_EXT_RISE
      |=> tick_o)
    else $error("rising external edge not counted");

endmodule

// ### src/tmr_timer16.sv
// Purpose: 16-bit timer with capture, two compare channels, APB registers
// Assumes: Zero-wait APB slave; byte registers in data bits 7:0
// Notes: Compare registers are not double buffered in PWM modes
//
// Local design decision: register access over APB.
module tmr_timer16 import tmr_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic capture_pin_i,
  input wire logic acomp_i,
  input wire logic ext_count_pin_i,
  input wire logic global_irq_en_i,
  input wire logic [3:0] vector_ack_i,
  output logic [3:0] irq_req_o,
  output logic wave_out_a_o,
  output logic wave_out_a_en_o,
  output logic wave_out_b_o,
  output logic wave_out_b_en_o
);

  logic [7:0] ctrl_a, ctrl_b, mask, temp_hi, rd_snap, rd_mux, next_snap, idx, wb;
  logic [15:0] count_value, capture_value, top_value;
  logic [15:0] cmp [2];
  logic [3:0] flg, waveform_mode, flag_set, flag_clr;
  logic [1:0] match, force_hit, at_top, wave, wave_en;
  logic src_acomp, addr_ok, setup, wr_en, rd_done, wr_cnt, wr_cap, dual, non_pwm;
  logic icr_top, tick, block_match, filt, cap_prev, cap_event, cap_top_hit, ovf_set;
  tmr_dir_t dir;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes without wait states
  assign idx = paddr_i[9:2];
  assign wb = pwdata_i[7:0];
  assign setup = psel_i & ~penable_i;
  assign pready_o = 1'b1;
  assign wr_en = psel_i & penable_i & pwrite_i & addr_ok & pstrb_i[0];
  assign rd_done = psel_i & penable_i & ~pwrite_i & addr_ok;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign wr_cnt = wr_en && idx == IDX_CNT_L;
  assign wr_cap = wr_en && idx == IDX_CAP_L;

  // Read mux; low-byte reads of counter and capture also snapshot the high byte
  always_comb begin
    addr_ok = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
    next_snap = temp_hi;
    case (idx)
      IDX_CTRL_A: rd_mux = ctrl_a;
      IDX_CTRL_B: rd_mux = ctrl_b;
      IDX_CTRL_C: rd_mux = RST_BYTE;
      IDX_AUX: rd_mux = {7'h00, src_acomp};
      IDX_CNT_L: begin
        rd_mux = count_value[7:0];
        next_snap = count_value[15:8];
      end
      IDX_CNT_H: rd_mux = temp_hi;
      IDX_CMPA_L: rd_mux = cmp[0][7:0];
      IDX_CMPA_H: rd_mux = cmp[0][15:8];
      IDX_CAP_L: begin
        rd_mux = capture_value[7:0];
        next_snap = capture_value[15:8];
      end
      IDX_CAP_H: rd_mux = temp_hi;
      IDX_CMPB_L: rd_mux = cmp[1][7:0];
      IDX_CMPB_H: rd_mux = cmp[1][15:8];
      IDX_MASK: rd_mux = mask;
      IDX_FLAGS: rd_mux = {2'h0, flg[3], 2'h0, flg[2], flg[1], flg[0]};
      default: begin
        rd_mux = RST_BYTE;
        addr_ok = 1'b0;
      end
    endcase
  end

  // Read data taken in the setup cycle so it leaves a flip-flop
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
      rd_snap <= RST_BYTE;
    end else if (setup) begin
      prdata_o <= {24'h000000, rd_mux};
      rd_snap <= next_snap;
    end
  end

  // Shared high-byte latch: filled by high writes and by counter and capture low reads
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      temp_hi <= RST_BYTE;
    end else if (wr_en && (idx == IDX_CNT_H || idx == IDX_CMPA_H ||
                           idx == IDX_CAP_H || idx == IDX_CMPB_H)) begin
      temp_hi <= wb;
    end else if (rd_done && (idx == IDX_CNT_L || idx == IDX_CAP_L)) begin
      temp_hi <= rd_snap;
    end
  end

  // Control and mask registers; reserved bits stay zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_a <= RST_BYTE;
      ctrl_b <= RST_BYTE;
      mask <= RST_BYTE;
      src_acomp <= 1'b0;
    end else if (wr_en) begin
      if (idx == IDX_CTRL_A) ctrl_a <= wb & CTLA_WMASK;
      if (idx == IDX_CTRL_B) ctrl_b <= wb & CTLB_WMASK;
      if (idx == IDX_MASK) mask <= wb & MASK_WMASK;
      if (idx == IDX_AUX) src_acomp <= wb[AUX_ACOMP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign waveform_mode = {ctrl_b[4:3], ctrl_a[1:0]};
  assign dual = SET_DUAL[waveform_mode];
  assign non_pwm = SET_NONPWM[waveform_mode];
  assign icr_top = SET_ICR_TOP[waveform_mode];

  // TOP by waveform mode; reserved mode runs as full range
  always_comb begin
    case (waveform_mode)
      4'h1, 4'h5: top_value = TOP_8;
      4'h2, 4'h6: top_value = TOP_9;
      4'h3, 4'h7: top_value = TOP_10;
      4'h4, 4'h9, 4'hb, 4'hf: top_value = cmp[0];
      4'h8, 4'ha, 4'hc, 4'he: top_value = capture_value;
      default: top_value = TOP_MAX;
    endcase
  end

  tmr_tick_gen u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clock_select_i(tmr_clk_sel_t'(ctrl_b[2:0])),
    .ext_count_pin_i(ext_count_pin_i),
    .tick_o(tick)
  );

  // Counter: software write wins; else one step per tick
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count_value <= RST_WORD;
      dir <= DIR_UP;
    end else if (wr_cnt) begin
      count_value <= {temp_hi, wb};
    end else if (tick) begin
      unique case (dir)
        DIR_UP: begin
          if (count_value >= top_value && dual) begin
            dir <= DIR_DOWN;
            count_value <= count_value - 16'h0001;
          end else if (count_value == top_value) begin
            count_value <= RST_WORD;
          end else begin
            count_value <= count_value + 16'h0001;
          end
        end
        DIR_DOWN: begin
          if (count_value == RST_WORD || !dual) begin
            dir <= DIR_UP;
            count_value <= count_value + 16'h0001;
          end else begin
            count_value <= count_value - 16'h0001;
          end
        end
      endcase
    end
  end

  // Counter write masks the match of the following tick
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      block_match <= 1'b0;
    end else if (wr_cnt) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture path: edge on filtered source, disabled when capture is TOP
  tmr_capture_filter u_filt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .capture_pin_i(capture_pin_i),
    .acomp_i(acomp_i),
    .src_acomp_i(src_acomp),
    .filter_en_i(ctrl_b[CTLB_FILT_BIT]),
    .filt_o(filt)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= filt;
    end
  end

  assign cap_event = !icr_top && (ctrl_b[CTLB_EDGE_BIT] ? (filt & ~cap_prev)
                                                        : (~filt & cap_prev));
  assign cap_top_hit = icr_top && tick && count_value == top_value;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      capture_value <= RST_WORD;
    end else if (wr_cap) begin
      capture_value <= {temp_hi, wb};
    end else if (cap_event) begin
      capture_value <= count_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow point per mode family
  assign ovf_set = tick && (non_pwm ? count_value == TOP_MAX
                          : dual ? (dir == DIR_DOWN && count_value == RST_WORD)
                          : count_value == top_value);

  // Flags: hardware set wins over any clear in the same cycle
  assign flag_set = {cap_event | cap_top_hit, match[1], match[0],
                     ovf_set};
  assign flag_clr = vector_ack_i | ({4{wr_en && idx == IDX_FLAGS}} &
                    {wb[FL_CAP_BIT], wb[FL_MB_BIT], wb[FL_MA_BIT], wb[FL_OV_BIT]});

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flg <= 4'h0;
    end else begin
      flg <= (flg & ~flag_clr) | flag_set;
    end
  end

  // Requests gated by mask and global enable
  assign irq_req_o = flg & {mask[5], mask[2], mask[1], mask[0]} & {4{global_irq_en_i}};

  ////////////////////////////////////////////////////////////////////////////
  // Compare channels: 0 is A, 1 is B
  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    localparam int COM_LSB = (ch == 0) ? CTLA_COM_A_LSB : CTLA_COM_B_LSB;
    localparam int FORCE_BIT = (ch == 0) ? CTLC_FORCE_A_BIT : CTLC_FORCE_B_BIT;
    logic [1:0] com;
    logic tog_ok;

    assign com = ctrl_a[COM_LSB+1:COM_LSB];
    assign tog_ok = (ch == 0) && SET_TOGGLE_A[waveform_mode];
    assign match[ch] = tick && !block_match && count_value == cmp[ch];
    // Strobe only, never stored; no flag, no counter effect
    assign force_hit[ch] = wr_en && idx == IDX_CTRL_C && wb[FORCE_BIT] && non_pwm;
    assign at_top[ch] = tick && !dual && count_value == top_value;
    assign wave_en[ch] = (com != 2'b00) && (non_pwm || com != 2'b01 || tog_ok);

    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        cmp[ch] <= RST_WORD;
      end else if (wr_en && idx == ((ch == 0) ? IDX_CMPA_L : IDX_CMPB_L)) begin
        cmp[ch] <= {temp_hi, wb};
      end
    end

    // Output action on match, forced match or TOP
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        wave[ch] <= 1'b0;
      end else if (non_pwm) begin
        if (match[ch] || force_hit[ch]) begin
          unique case (com)
            2'b00: wave[ch] <= wave[ch];
            2'b01: wave[ch] <= ~wave[ch];
            2'b10: wave[ch] <= 1'b0;
            2'b11: wave[ch] <= 1'b1;
          endcase
        end
      end else if (com == 2'b01) begin
        if (match[ch] && tog_ok) wave[ch] <= ~wave[ch];
      end else if (com[1]) begin
        if (match[ch]) wave[ch] <= com[0] ^ (dual && dir == DIR_DOWN);
        else if (at_top[ch]) wave[ch] <= ~com[0];
      end
    end
  end

  assign wave_out_a_o = wave[0];
  assign wave_out_b_o = wave[1];
  assign wave_out_a_en_o = wave_en[0];
  assign wave_out_b_en_o = wave_en[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cnt_write;
    wr_cnt;
  endsequence
  sequence s_tick_next;
    tick;
  endsequence

  a_write_blocks: assert property (s_cnt_write ##1 s_tick_next |-> match == 2'b00)
    else $error("match not suppressed after counter write");
  a_capture_copy: assert property (cap_event && !wr_cap
    |=> capture_value == $past(count_value) && flg[3])
    else $error("capture did not copy counter or set flag");
  a_edge_falling: assert property (!ctrl_b[CTLB_EDGE_BIT] && filt && !cap_prev && !wr_cap
    |=> $stable(capture_value))
    else $error("rising edge captured while falling edge selected");
  a_icr_top_nocap: assert property (icr_top && filt != cap_prev && !wr_cap
    |=> $stable(capture_value))
    else $error("capture while capture value is TOP");
  a_force_quiet: assert property (force_hit[0] && !match[0] && !flg[1] |=> !flg[1])
    else $error("forced match set compare flag");
  a_force_no_irq: assert property (force_hit[0] && !match[0] && !flg[1] |=> !irq_req_o[1])
    else $error("forced match raised request");
  a_force_reads_zero: assert property (setup && idx == IDX_CTRL_C |=> prdata_o == 32'h0)
    else $error("control C read not zero");
  a_flag_set_wins: assert property (match[0] |=> flg[1])
    else $error("compare flag lost");
  a_flag_w1c: assert property (wr_en && idx == IDX_FLAGS && wb[0] && !ovf_set |=> !flg[0])
    else $error("overflow flag not cleared by write one");
  a_ovf_normal: assert property (waveform_mode == WGM_NORMAL && tick && !wr_cnt &&
    count_value == TOP_MAX |=> flg[0] && count_value == RST_WORD)
    else $error("normal overflow wrong");
  a_normal_step: assert property (waveform_mode == WGM_NORMAL && tick && !wr_cnt
    |=> count_value == 16'($past(count_value) + 16'h0001))
    else $error("normal mode step wrong");
  a_irq_gate: assert property (match[0] && mask[1] ##1 global_irq_en_i && mask[1]
    |-> irq_req_o[1])
    else $error("compare A request missing");

endmodule

// ### test/tb_top.sv
// Purpose: Self-checking bench of the 16-bit timer over APB and pins
// Assumes: Zero-wait slave, byte registers at index * 4
// Notes: Reads queue expected bytes; a monitor compares them
module tb_top import tmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, gie = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] ack = '0, irq;
  logic pready, pslverr, cap, ext, wa, wb, wae, wbe;
  logic [7:0] expq[$];
  logic [15:0] r;
  int n_mismatch = 0, checked = 0;
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  tmr_timer16 dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .capture_pin_i(cap), .acomp_i(ext),
    .ext_count_pin_i(ext), .global_irq_en_i(gie), .vector_ack_i(ack), .irq_req_o(irq),
    .wave_out_a_o(wa), .wave_out_a_en_o(wae), .wave_out_b_o(wb), .wave_out_b_en_o(wbe));
  tmr_pins_model model_u (.ref_clk_i(ref_clk_i), .cap_o(cap), .ext_o(ext));
  ////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One APB transfer; a read queues its expected byte
  task automatic xfer(input bit w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!w) expq.push_back(d);
    @(posedge ref_clk_i);
    pen <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // High byte first so the shared latch pairs them
  task automatic w16(input logic [7:0] ih, input logic [7:0] il, input logic [15:0] v);
    xfer(1, ih, v[15:8]);
    xfer(1, il, v[7:0]);
  endtask
  // Land past the edge so its updates are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Monitor: each completed read takes the oldest note
  always @(posedge ref_clk_i) begin
    if (psel && pen && pready && !pwr && expq.size() > 0)
      chk("prdata", expq.pop_front(), prdata[7:0]);
    // Only index 0x8c of the used range is unmapped
    if (psel && pen && pready)
      chk("pslverr", {7'h0, paddr[9:2] == 8'h8c}, {7'h0, pslverr});
  end
  // Watchdog well beyond the expected run
  initial begin
    #(25 * 20000);
    n_mismatch++;
    conclude();
  end
  ////////////////////////////////////////////////
  initial begin
    r = 16'($urandom(32'hdd48));
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    xfer(0, IDX_CTRL_B, RST_BYTE);
    xfer(0, IDX_CMPB_H, RST_BYTE);
    xfer(1, IDX_CTRL_C, 8'hff);
    xfer(0, IDX_CTRL_C, 8'h00);
    xfer(0, 8'h8c, 8'h00);
    // Forced match: set A in normal mode, B ignored in PWM
    xfer(1, IDX_CTRL_A, 8'hc0);
    xfer(1, IDX_CTRL_C, 8'h80);
    cyc(2);
    chk("wave_a", 8'h01, {7'h0, wa});
    chk("wave_a_en", 8'h01, {7'h0, wae});
    // Toggle mode flips the output on a forced match
    xfer(1, IDX_CTRL_A, 8'h40);
    xfer(1, IDX_CTRL_C, 8'h80);
    cyc(2);
    chk("wave_a", 8'h00, {7'h0, wa});
    xfer(0, IDX_FLAGS, 8'h00);
    xfer(1, IDX_CTRL_A, 8'h31);
    xfer(1, IDX_CTRL_C, 8'h40);
    cyc(2);
    chk("wave_b", 8'h00, {7'h0, wb});
    chk("wave_b_en", 8'h01, {7'h0, wbe});
    xfer(1, IDX_CTRL_C, RST_BYTE);
    xfer(1, IDX_CTRL_A, 8'h00);
    // Rising pin edge captures the stopped counter
    r = 16'($urandom);
    w16(IDX_CNT_H, IDX_CNT_L, r);
    xfer(1, IDX_CTRL_B, 8'h40);
    model_u.pulse(1'b0, 1);
    cyc(10);
    xfer(0, IDX_CAP_L, r[7:0]);
    xfer(0, IDX_CAP_H, r[15:8]);
    xfer(0, IDX_FLAGS, 8'h20);
    xfer(1, IDX_FLAGS, 8'h20);
    xfer(0, IDX_FLAGS, 8'h00);
    // Filtered falling edge of the comparator captures; a rising one must not
    r = 16'($urandom);
    w16(IDX_CNT_H, IDX_CNT_L, r);
    xfer(1, IDX_AUX, 8'h01);
    xfer(1, IDX_CTRL_B, 8'h80);
    model_u.pulse(1'b1, 1);
    cyc(12);
    xfer(0, IDX_CAP_L, r[7:0]);
    xfer(0, IDX_CAP_H, r[15:8]);
    xfer(1, IDX_FLAGS, 8'h20);
    // Capture value as TOP: a pin edge leaves value and flag alone
    xfer(1, IDX_AUX, 8'h00);
    w16(IDX_CNT_H, IDX_CNT_L, ~r);
    xfer(1, IDX_CTRL_B, 8'h58);
    model_u.pulse(1'b0, 1);
    cyc(12);
    xfer(0, IDX_CAP_L, r[7:0]);
    xfer(0, IDX_FLAGS, 8'h00);
    // Count pin: three rising, then three falling edges
    w16(IDX_CNT_H, IDX_CNT_L, 16'h0000);
    xfer(1, IDX_CTRL_B, 8'h07);
    model_u.pulse(1'b1, 3);
    cyc(8);
    xfer(1, IDX_CTRL_B, 8'h06);
    model_u.pulse(1'b1, 3);
    cyc(8);
    xfer(1, IDX_CTRL_B, 8'h00);
    xfer(0, IDX_CNT_L, 8'h06);
    // Wrap past the top, then matches on A and B
    w16(IDX_CMPA_H, IDX_CMPA_L, 16'h0008);
    w16(IDX_CMPB_H, IDX_CMPB_L, 16'h0009);
    w16(IDX_CNT_H, IDX_CNT_L, 16'hfff0);
    xfer(1, IDX_MASK, 8'h27);
    gie <= 1'b1;
    xfer(1, IDX_CTRL_B, 8'h01);
    cyc(40);
    chk("irq", 8'h07, {4'h0, irq});
    xfer(0, IDX_FLAGS, 8'h07);
    ack <= 4'h1;
    @(posedge ref_clk_i);
    ack <= 4'h0;
    xfer(1, IDX_FLAGS, 8'h06);
    cyc(2);
    chk("irq", 8'h00, {4'h0, irq});
    conclude();
  end
endmodule

// ### test/tmr_pins_model.sv
// Purpose: Pin-side partner driving capture and external count pins
// Assumes: Each level held four clocks, exactly the four-sample filter window
// Notes: Both pins rest low between pulses
module tmr_pins_model (
  input wire logic ref_clk_i,
  output logic cap_o,
  output logic ext_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cap_o = 1'b0;
    ext_o = 1'b0;
  end
  // Full pulses on one pin; sel picks the count pin
  task automatic pulse(input bit sel, input int n);
    repeat (n) begin
      repeat (4) @(posedge ref_clk_i);
      {ext_o, cap_o} <= {sel, !sel};
      repeat (4) @(posedge ref_clk_i);
      {ext_o, cap_o} <= 2'b00;
    end
  endtask
endmodule
